// file: common/bss_map.svh
// Register offsets, field positions, reset values and timing counts of the startup sequencer
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH
`define BSS_OFF_RES 8'h00
`define BSS_OFF_IND 8'h04
`define BSS_OFF_BEMF 8'h08
`define BSS_OFF_CFG 8'h0c
`define BSS_OFF_CTRL 8'h10
`define BSS_OFF_STAT 8'h14
`define BSS_OFF_SPEED 8'h18
`define BSS_OFF_PERIOD 8'h1c
`define BSS_CFG_PSL 0
`define BSS_CFG_SCL 3
`define BSS_CFG_RA1 6
`define BSS_CFG_RA2 9
`define BSS_CFG_HOV 12
`define BSS_CFG_REVEN 17
`define BSS_CFG_REVV 18
`define BSS_CFG_PSDSEL 21
`define BSS_CFG_ALV 22
`define BSS_CFG_ALT 25
`define BSS_CFG_MASK 32'h1fff_ffff
`define BSS_CFG_RST 32'h0880_8000
`define BSS_PARA_RST 12'h000
`define BSS_CLK_KHZ 10000
`define BSS_TICK_US 100
`define BSS_TICK_CYC ((`BSS_TICK_US * `BSS_CLK_KHZ) / 1000)
`define BSS_PSD_TO_US 300
`define BSS_PSD_TO_CYC ((`BSS_PSD_TO_US * `BSS_CLK_KHZ) / 1000)
`define BSS_PSD_GAP_US 100
`define BSS_PSD_GAP_CYC ((`BSS_PSD_GAP_US * `BSS_CLK_KHZ + 999) / 1000)
`define BSS_STILL_MS 200
`define BSS_STILL_CYC (`BSS_STILL_MS * `BSS_CLK_KHZ)
`define BSS_ALIGN_UNIT 64
`define BSS_ALIGN_STEP 16
`define BSS_SPD_SH 6
`define BSS_KT_SH 12
`endif

// file: common/bss_pkg.sv
// Types shared by the startup sequencer
package bss_pkg;
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_DETECT  = 4'b0001,
        ST_ALIGN   = 4'b0010,
        ST_PSENSE  = 4'b0011,
        ST_OPEN    = 4'b0100,
        ST_REVERSE = 4'b0101,
        ST_BRAKE   = 4'b0110,
        ST_CLOSED  = 4'b0111
    } bss_state_e;
    typedef enum logic [1:0] {
        INIT_NONE  = 2'b00,
        INIT_STILL = 2'b01,
        INIT_FWD   = 2'b10,
        INIT_REV   = 2'b11
    } bss_init_e;
endpackage

// file: design/bss_startup_sequencer.sv
// Sensorless brushless motor startup sequencer with AHB-Lite register slave
`timescale 1ns/1ps
`include "bss_map.svh"

module bss_startup_sequencer
    import bss_pkg::*;
#(
    parameter int STILL_CYC = `BSS_STILL_CYC,
    parameter int SPD_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic cmpUV,
    input wire logic cmpVW,
    input wire logic currAtLimit,
    output logic [2:0] phaseHighOn,
    output logic [2:0] phaseLowOn,
    output logic modEnable,
    output logic [15:0] driveAngle,
    output logic [15:0] startupVoltageAmplitude,
    output logic [2:0] positionSenseCurrentLimit,
    output logic closedLoopGo,
    output logic [31:0] commPeriod
);
    localparam int GW = $clog2(STILL_CYC + 1);
    localparam logic [GW-1:0] STILL_LIM = GW'(STILL_CYC - 1);
    localparam logic [9:0] TICK_LIM = 10'(`BSS_TICK_CYC - 1);
    localparam logic [12:0] PSD_TO = 13'(`BSS_PSD_TO_CYC);
    localparam logic [12:0] PSD_GAP = 13'(`BSS_PSD_GAP_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    logic [11:0] resCode_q;
    logic [11:0] indCode_q;
    logic [11:0] bemfCode_q;
    logic [31:0] cfg_q;
    logic run_q;
    logic dPhase_q;
    logic dWrite_q;
    logic [7:0] dAddr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rdMux;
    bss_state_e state_q;
    bss_init_e initState;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] prev_q;
    logic aEdge;
    logic anyEdge;
    logic [GW-1:0] gap_q;
    logic [GW-1:0] gapA_q;
    logic [GW-1:0] period_q;
    logic [1:0] edgeCnt_q;
    logic dirFwd_q;
    logic still;
    logic [9:0] tickCnt_q;
    logic tick;
    logic signed [SPD_W-1:0] speed_q;
    logic [SPD_W-1:0] absSpeed;
    logic [SPD_W-1:0] hovSpeed;
    logic [SPD_W-1:0] rate;
    logic [15:0] angle_q;
    logic [15:0] amp_q;
    logic [15:0] alignTarget;
    logic [10:0] alignCnt_q;
    logic alignDone;
    logic [2:0] pulseIdx_q;
    logic pulseOn_q;
    logic [12:0] pulseCnt_q;
    logic [12:0] pulseTo;
    logic [12:0] bestTime_q;
    logic [2:0] bestIdx_q;
    logic psDone_q;
    logic [2:0] hiOn_q;
    logic [2:0] loOn_q;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] pairHigh(input logic [2:0] idx);
        case (idx)
            3'h0, 3'h1: pairHigh = 2'h0;
            3'h2, 3'h3: pairHigh = 2'h1;
            default: pairHigh = 2'h2;
        endcase
    endfunction

    function automatic logic [1:0] pairLow(input logic [2:0] idx);
        case (idx)
            3'h0, 3'h5: pairLow = 2'h1;
            3'h3, 3'h4: pairLow = 2'h0;
            default: pairLow = 2'h2;
        endcase
    endfunction

    // Electrical angle of each sensing pair vector, full turn is 2^16
    function automatic logic [15:0] pairAngle(input logic [2:0] idx);
        case (idx)
            3'h0: pairAngle = 16'h1555;
            3'h1: pairAngle = 16'heaab;
            3'h2: pairAngle = 16'h4000;
            3'h3: pairAngle = 16'h9555;
            3'h4: pairAngle = 16'h6aab;
            default: pairAngle = 16'hc000;
        endcase
    endfunction

    // Saturating (level+1)*R + K*|speed|/4096, units of the modulator full scale
    function automatic logic [15:0] stAmp(input logic [2:0] lvl, input logic [11:0] res,
                                          input logic [11:0] kt, input logic [SPD_W-1:0] spd);
        logic [16:0] ir;
        logic [SPD_W+11:0] ks;
        logic [17:0] sum;
        ir = 17'({1'b0, lvl} + 4'h1) * 17'(res);
        ks = (SPD_W + 12)'(kt) * (SPD_W + 12)'(spd);
        sum = 18'(ir) + 18'(ks >> `BSS_KT_SH);
        stAmp = (sum > 18'h0ffff) ? 16'hffff : sum[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dPhase_q <= 1'b0;
            dWrite_q <= 1'b0;
            dAddr_q <= 8'h00;
        end else if (hready) begin
            dPhase_q <= hsel & htrans[1];
            dWrite_q <= hwrite;
            dAddr_q <= haddr[7:0];
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        case (haddr[7:0])
            `BSS_OFF_RES: rdMux = {20'h00000, resCode_q};
            `BSS_OFF_IND: rdMux = {20'h00000, indCode_q};
            `BSS_OFF_BEMF: rdMux = {20'h00000, bemfCode_q};
            `BSS_OFF_CFG: rdMux = cfg_q;
            `BSS_OFF_CTRL: rdMux = {31'h0000_0000, run_q};
            `BSS_OFF_STAT: rdMux = {22'h000000, closedLoopGo, bestIdx_q, initState, state_q};
            `BSS_OFF_SPEED: rdMux = 32'(speed_q);
            `BSS_OFF_PERIOD: rdMux = 32'(period_q);
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata_q <= rdMux;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            resCode_q <= `BSS_PARA_RST;
            indCode_q <= `BSS_PARA_RST;
            bemfCode_q <= `BSS_PARA_RST;
            cfg_q <= `BSS_CFG_RST;
            run_q <= 1'b0;
        end else if (dPhase_q && dWrite_q) begin
            case (dAddr_q)
                `BSS_OFF_RES: resCode_q <= hwdata[11:0];
                `BSS_OFF_IND: indCode_q <= hwdata[11:0];
                `BSS_OFF_BEMF: bemfCode_q <= hwdata[11:0];
                `BSS_OFF_CFG: cfg_q <= hwdata & `BSS_CFG_MASK;
                `BSS_OFF_CTRL: run_q <= hwdata[0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin inputs: comparators and current limit cross into clk domain
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 3'h0;
        end else begin
            sync1_q <= {currAtLimit, cmpVW, cmpUV};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign aEdge = sync2_q[0] ^ prev_q[0];
    assign anyEdge = aEdge | (sync2_q[1] ^ prev_q[1]);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tickCnt_q <= 10'h000;
        end else begin
            tickCnt_q <= (tickCnt_q == TICK_LIM) ? 10'h000 : tickCnt_q + 10'h001;
        end
    end
    assign tick = (tickCnt_q == TICK_LIM);

    ////////////////////////////////////////////////////////////////////////////////
    // Initial state detect while phases coast, standstill detect while braking
    always_ff @(posedge clk) begin
        if (!rstn || (state_q != ST_DETECT && state_q != ST_BRAKE)) begin
            gap_q <= '0;
            gapA_q <= '0;
            edgeCnt_q <= 2'h0;
            dirFwd_q <= 1'b0;
        end else begin
            if (anyEdge) begin
                gap_q <= '0;
            end else if (gap_q != STILL_LIM) begin
                gap_q <= gap_q + GW'(1);
            end
            if (aEdge) begin
                gapA_q <= '0;
                dirFwd_q <= sync2_q[0] ^ sync2_q[1];
                if (edgeCnt_q != 2'h3) begin
                    edgeCnt_q <= edgeCnt_q + 2'h1;
                end
            end else if (gapA_q != STILL_LIM) begin
                gapA_q <= gapA_q + GW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            period_q <= '0;
        end else if (state_q == ST_DETECT && aEdge && edgeCnt_q != 2'h0) begin
            // The edge cycle itself belongs to the period
            period_q <= gapA_q + GW'(1);
        end
    end

    // Standstill: no edge on either comparator for the whole window
    assign still = (gap_q == STILL_LIM);

    always_comb begin
        if (still) begin
            initState = INIT_STILL;
        end else if (edgeCnt_q >= 2'h2) begin
            initState = dirFwd_q ? INIT_FWD : INIT_REV;
        end else begin
            initState = INIT_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign hovSpeed = SPD_W'({cfg_q[`BSS_CFG_HOV +: 5], 6'h00});
    assign absSpeed = speed_q[SPD_W-1] ? SPD_W'(-speed_q) : SPD_W'(speed_q);
    assign rate = (absSpeed < (hovSpeed >> 1)) ? SPD_W'({1'b0, cfg_q[`BSS_CFG_RA1 +: 3]} + 4'h1)
                                              : SPD_W'({1'b0, cfg_q[`BSS_CFG_RA2 +: 3]} + 4'h1);
    assign alignTarget = {1'b0, cfg_q[`BSS_CFG_ALV +: 3], 12'h000} + 16'h1000;
    assign alignDone = (alignCnt_q == 11'({1'b0, cfg_q[`BSS_CFG_ALT +: 4]} + 5'h01) * 11'(`BSS_ALIGN_UNIT));
    assign pulseTo = PSD_TO + 13'(indCode_q);

    always_ff @(posedge clk) begin
        if (!rstn || !run_q) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= ST_DETECT;
                ST_DETECT: begin
                    if (initState == INIT_STILL) begin
                        state_q <= cfg_q[`BSS_CFG_PSDSEL] ? ST_PSENSE : ST_ALIGN;
                    end else if (initState == INIT_FWD && aEdge) begin
                        state_q <= ST_CLOSED;
                    end else if (initState == INIT_REV) begin
                        state_q <= cfg_q[`BSS_CFG_REVEN] ? ST_REVERSE : ST_BRAKE;
                    end
                end
                ST_BRAKE: begin
                    if (still) begin
                        state_q <= cfg_q[`BSS_CFG_PSDSEL] ? ST_PSENSE : ST_ALIGN;
                    end
                end
                ST_ALIGN: if (alignDone) state_q <= ST_OPEN;
                ST_PSENSE: if (psDone_q) state_q <= ST_OPEN;
                ST_OPEN, ST_REVERSE: begin
                    if (!speed_q[SPD_W-1] && SPD_W'(speed_q) >= hovSpeed) begin
                        state_q <= ST_CLOSED;
                    end
                end
                ST_CLOSED: state_q <= ST_CLOSED;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Open-loop vector: speed ramps per tick, angle integrates speed
    always_ff @(posedge clk) begin
        if (!rstn) begin
            speed_q <= '0;
            angle_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    speed_q <= '0;
                    angle_q <= 16'h0000;
                end
                ST_DETECT: begin
                    // Reverse spin starts backward at the handover speed
                    speed_q <= (initState == INIT_REV) ? -$signed(hovSpeed) : '0;
                    if (aEdge) begin
                        angle_q <= sync2_q[0] ? 16'h0000 : 16'h8000;
                    end
                end
                ST_ALIGN: begin
                    speed_q <= '0;
                    angle_q <= 16'h0000;
                end
                ST_PSENSE: begin
                    speed_q <= '0;
                    if (psDone_q) begin
                        angle_q <= pairAngle(bestIdx_q);
                    end
                end
                ST_OPEN, ST_REVERSE: begin
                    if (tick) begin
                        speed_q <= speed_q + $signed(rate);
                        angle_q <= angle_q + 16'(speed_q);
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            amp_q <= 16'h0000;
        end else begin
            case (state_q)
                ST_ALIGN: begin
                    if (tick && amp_q < alignTarget) begin
                        amp_q <= (alignTarget - amp_q > 16'(`BSS_ALIGN_STEP))
                                 ? amp_q + 16'(`BSS_ALIGN_STEP) : alignTarget;
                    end
                end
                ST_OPEN: amp_q <= stAmp(cfg_q[`BSS_CFG_SCL +: 3], resCode_q, bemfCode_q, absSpeed);
                ST_REVERSE: amp_q <= stAmp(cfg_q[`BSS_CFG_REVV +: 3], resCode_q, bemfCode_q, absSpeed);
                ST_CLOSED: amp_q <= amp_q;
                default: amp_q <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn || state_q != ST_ALIGN) begin
            alignCnt_q <= 11'h000;
        end else if (tick && !alignDone) begin
            alignCnt_q <= alignCnt_q + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Inductive pulse sensing: six pulses, shortest rise marks the rotor
    always_ff @(posedge clk) begin
        if (!rstn || state_q != ST_PSENSE) begin
            pulseIdx_q <= 3'h0;
            pulseOn_q <= 1'b1;
            pulseCnt_q <= 13'h0000;
            bestTime_q <= 13'h1fff;
            bestIdx_q <= (rstn && (state_q == ST_OPEN || state_q == ST_CLOSED)) ? bestIdx_q : 3'h0;
            psDone_q <= 1'b0;
        end else if (pulseOn_q) begin
            if (sync2_q[2] || pulseCnt_q == pulseTo) begin
                pulseOn_q <= 1'b0;
                pulseCnt_q <= 13'h0000;
                if (pulseCnt_q < bestTime_q) begin
                    bestTime_q <= pulseCnt_q;
                    bestIdx_q <= pulseIdx_q;
                end
            end else begin
                pulseCnt_q <= pulseCnt_q + 13'h0001;
            end
        end else if (!psDone_q) begin
            // Gap lets the winding current decay before the next pair
            if (pulseCnt_q == PSD_GAP) begin
                pulseCnt_q <= 13'h0000;
                if (pulseIdx_q == 3'h5) begin
                    psDone_q <= 1'b1;
                end else begin
                    pulseIdx_q <= pulseIdx_q + 3'h1;
                    pulseOn_q <= 1'b1;
                end
            end else begin
                pulseCnt_q <= pulseCnt_q + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hiOn_q <= 3'h0;
            loOn_q <= 3'h0;
        end else begin
            case (state_q)
                ST_PSENSE: begin
                    hiOn_q <= (pulseOn_q && !psDone_q) ? 3'(3'h1 << pairHigh(pulseIdx_q)) : 3'h0;
                    loOn_q <= (pulseOn_q && !psDone_q) ? 3'(3'h1 << pairLow(pulseIdx_q)) : 3'h0;
                end
                ST_BRAKE: begin
                    hiOn_q <= 3'h0;
                    loOn_q <= 3'h7;
                end
                default: begin
                    hiOn_q <= 3'h0;
                    loOn_q <= 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            modEnable <= 1'b0;
            closedLoopGo <= 1'b0;
            positionSenseCurrentLimit <= 3'h0;
        end else begin
            modEnable <= (state_q == ST_ALIGN) || (state_q == ST_OPEN) ||
                         (state_q == ST_REVERSE) || (state_q == ST_CLOSED);
            closedLoopGo <= (state_q == ST_CLOSED);
            positionSenseCurrentLimit <= cfg_q[`BSS_CFG_PSL +: 3];
        end
    end

    assign phaseHighOn = hiOn_q;
    assign phaseLowOn = loOn_q;
    assign driveAngle = angle_q;
    assign startupVoltageAmplitude = amp_q;
    assign commPeriod = 32'(period_q);
endmodule

// file: test/bss_startup_sequencer_props.sv
// Port checker for the startup sequencer
`timescale 1ns/1ps
module bss_startup_sequencer_props #(
    parameter int STILL_CYC = 200,
    parameter int SPD_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic currAtLimit,
    input wire logic [2:0] phaseHighOn,
    input wire logic [2:0] phaseLowOn,
    input wire logic modEnable,
    input wire logic closedLoopGo
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    reset_quiet_a: assert property (disable iff (1'b0) !rstn |=> phaseHighOn == 3'h0 && phaseLowOn == 3'h0
        && !modEnable && !closedLoopGo) else $error("drive active after reset");
    no_shoot_a: assert property ((phaseHighOn & phaseLowOn) == 3'h0)
        else $error("high and low side on together");
    pulse_pair_a: assert property (!modEnable && phaseHighOn != 3'h0 |->
        $onehot(phaseHighOn) && $onehot(phaseLowOn)) else $error("pulse not across one pair");
    pulse_end_a: assert property ($rose(currAtLimit) && !modEnable && phaseHighOn != 3'h0
        |-> ##[1:5] phaseHighOn == 3'h0) else $error("pulse outlived current limit");
    float_idle_a: assert property (!modEnable && phaseHighOn == 3'h0 |->
        phaseLowOn == 3'h0 || phaseLowOn == 3'h7) else $error("partial low side drive");
    brake_lows_a: assert property (phaseLowOn == 3'h7 |-> !modEnable && !closedLoopGo)
        else $error("brake mixed with drive");
    closed_drive_a: assert property (closedLoopGo |-> modEnable)
        else $error("closed loop without modulator");
    cover property ($rose(closedLoopGo));
    cover property (phaseLowOn == 3'h7);
    cover property ($rose(currAtLimit) && phaseHighOn != 3'h0);
endmodule
bind bss_startup_sequencer bss_startup_sequencer_props #(.STILL_CYC(STILL_CYC), .SPD_W(SPD_W)) i_props (
    .clk(clk), .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp), .currAtLimit(currAtLimit),
    .phaseHighOn(phaseHighOn), .phaseLowOn(phaseLowOn), .modEnable(modEnable), .closedLoopGo(closedLoopGo));

// file: test/bss_motor_model.sv
// Behavioural motor windings and comparators behind the half-bridges
`timescale 1ns/1ps
module bss_motor_model #(
    parameter int Q = 100
) (
    input wire logic clk,
    input wire logic [1:0] spinMode,
    input wire logic [2:0] phaseHighOn,
    input wire logic [2:0] phaseLowOn,
    output logic cmpUV,
    output logic cmpVW,
    output logic currAtLimit
);
    int qc = 0;
    int ic = 0;
    logic [1:0] p = 2'h0;
    // Comparators stand still when the rotor stops
    always @(posedge clk) begin
        if (spinMode != 2'h0) begin
            qc <= (qc == Q - 1) ? 0 : qc + 1;
            p <= (qc == Q - 1) ? p + 2'h1 : p;
        end
        ic <= (phaseHighOn != 3'h0 && phaseLowOn != 3'h0) ? ic + 1 : 0;
    end
    // Mode 2 lets the V-W zero crossing lead, i.e. reverse spin
    assign cmpUV = (spinMode == 2'h2) ? p[1] : p[1] ^ p[0];
    assign cmpVW = (spinMode == 2'h2) ? p[1] ^ p[0] : p[1];
    // Pair V to U sees the least inductance, so it rises fastest
    assign currAtLimit = ic >= ((phaseHighOn == 3'h2 && phaseLowOn == 3'h1) ? 200 : 400);
endmodule

// file: test/bss_startup_sequencer_tb.sv
// Register and startup sequence tests of the startup sequencer
`timescale 1ns/1ps
`include "bss_map.svh"
module bss_startup_sequencer_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] spinMode = 2'h0;
    logic [31:0] hrdata, commPeriod, rd;
    logic hreadyout, hresp, cmpUV, cmpVW, currAtLimit, modEnable, closedLoopGo;
    logic [2:0] phaseHighOn, phaseLowOn, positionSenseCurrentLimit;
    logic [15:0] driveAngle, startupVoltageAmplitude, amp;
    logic [5:0] pairs [6] = '{6'h0a, 6'h0c, 6'h14, 6'h11, 6'h21, 6'h22};
    int nMismatch = 0;
    int nTests = 0;
    int cyc = 0;
    int i, k;
    always #50 clk = ~clk;
    bss_startup_sequencer #(.STILL_CYC(200), .SPD_W(16)) i_dut (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmpUV(cmpUV), .cmpVW(cmpVW),
        .currAtLimit(currAtLimit), .phaseHighOn(phaseHighOn), .phaseLowOn(phaseLowOn), .modEnable(modEnable),
        .driveAngle(driveAngle), .startupVoltageAmplitude(startupVoltageAmplitude),
        .positionSenseCurrentLimit(positionSenseCurrentLimit), .closedLoopGo(closedLoopGo), .commPeriod(commPeriod));
    bss_motor_model #(.Q(100)) i_motor (.clk(clk), .spinMode(spinMode), .phaseHighOn(phaseHighOn),
        .phaseLowOn(phaseLowOn), .cmpUV(cmpUV), .cmpVW(cmpVW), .currAtLimit(currAtLimit));
    ////////////////////////////////////////////////////////////////
    task automatic endSim;
        $display("Comparisons %0d, mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        nTests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            nMismatch++;
        end
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    // Stop first so the new settings apply to a fresh start
    task automatic run(input logic [31:0] cfg, input logic [1:0] sm);
        xfer(1'b1, `BSS_OFF_CTRL, 32'h0);
        xfer(1'b1, `BSS_OFF_CFG, cfg);
        spinMode <= sm;
        xfer(1'b1, `BSS_OFF_CTRL, 32'h1);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            nMismatch++;
            endSim();
        end
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 3; k++) begin
            rdChk(8'(4 * k), 32'h0, "motor code reset");
            xfer(1'b1, 8'(4 * k), 32'hffff_ffff);
            rdChk(8'(4 * k), 32'h0000_0fff, "motor code width");
        end
        rdChk(`BSS_OFF_CFG, 32'h0880_8000, "cfg reset");
        xfer(1'b1, `BSS_OFF_CFG, 32'hffff_ffff);
        rdChk(`BSS_OFF_CFG, 32'h1fff_ffff, "cfg fields");
        xfer(1'b1, 8'h40, 32'h1234_5678);
        rdChk(8'h40, 32'h0, "unmapped");
        xfer(1'b1, `BSS_OFF_RES, 32'h100);
        xfer(1'b1, `BSS_OFF_IND, 32'h10);
        xfer(1'b1, `BSS_OFF_BEMF, 32'h0);
        run(32'h0020_1ad5, 2'h0);
        chk("sense limit", 32'h5, {29'h0, positionSenseCurrentLimit});
        for (k = 0; k < 6; k++) begin
            for (i = 0; i < 5000 && phaseHighOn == 3'h0; i++) @(posedge clk);
            chk("pulse pair", {26'h0, pairs[k]}, {26'h0, phaseHighOn, phaseLowOn});
            for (i = 0; i < 5000 && phaseHighOn != 3'h0; i++) @(posedge clk);
        end
        for (i = 0; i < 5000 && modEnable !== 1'b1; i++) @(posedge clk);
        chk("sensed angle", 32'h9555, {16'h0, driveAngle});
        repeat (1100) @(posedge clk);
        xfer(1'b0, `BSS_OFF_STAT, 32'h0);
        chk("open state", 32'h4, {28'h0, rd[3:0]});
        chk("open amplitude", 32'h300, {16'h0, startupVoltageAmplitude});
        for (i = 0; i < 20000 && closedLoopGo !== 1'b1; i++) @(posedge clk);
        rdChk(`BSS_OFF_SPEED, 32'h44, "handover speed");
        run(32'h0000_1ad5, 2'h0);
        for (i = 0; i < 3000 && modEnable !== 1'b1; i++) @(posedge clk);
        chk("align angle", 32'h0, {16'h0, driveAngle});
        amp = startupVoltageAmplitude;
        repeat (1000) @(posedge clk);
        chk("align ramp", {16'h0, amp + 16'h10}, {16'h0, startupVoltageAmplitude});
        xfer(1'b1, `BSS_OFF_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk("abort floats", 32'h0, {25'h0, modEnable, phaseHighOn, phaseLowOn});
        run(32'h0020_1ad5, 2'h2);
        for (i = 0; i < 3000 && phaseLowOn !== 3'h7; i++) @(posedge clk);
        chk("brake lows", 32'h7, {29'h0, phaseLowOn});
        spinMode <= 2'h0;
        for (i = 0; i < 3000 && phaseHighOn == 3'h0; i++) @(posedge clk);
        xfer(1'b0, `BSS_OFF_STAT, 32'h0);
        chk("sense after brake", 32'h3, {28'h0, rd[3:0]});
        xfer(1'b1, `BSS_OFF_BEMF, 32'h800);
        run(32'h0022_1ad5, 2'h2);
        for (i = 0; i < 3000 && modEnable !== 1'b1; i++) @(posedge clk);
        chk("counter amplitude", 32'h120, {16'h0, startupVoltageAmplitude});
        xfer(1'b0, `BSS_OFF_STAT, 32'h0);
        chk("counter drive", 32'h5, {28'h0, rd[3:0]});
        run(32'h0020_1ad5, 2'h1);
        for (i = 0; i < 3000 && closedLoopGo !== 1'b1; i++) @(posedge clk);
        chk("caught period", 32'h0000_00c8, commPeriod);
        chk("caught angle", cmpUV ? 32'h0 : 32'h8000, {16'h0, driveAngle});
        xfer(1'b1, `BSS_OFF_CTRL, 32'h0);
        spinMode <= 2'h0;
        endSim();
    end
endmodule
